//--- ccdmx_seq.sv
// channel mux sequencer, sampling strobes, gain/offset codes and output formatter
// assumes strobes and converter clock are outside pins much slower than sys_clk_i,
// and conv_valid_i comes from logic on sys_clk_i before the next data strobe fall
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module ccdmx_seq #(
   parameter bit NARROW_VARIANT = 1'b0 // 1: demux only, middle byte lanes
) (
   input wire logic sys_clk_i, // 20 MHz clock
   input wire logic rst_i, // async reset, high
   input wire logic [4:0] avs_address_i, // byte address
   input wire logic avs_read_i, // read request
   input wire logic avs_write_i, // write request
   input wire logic [31:0] avs_writedata_i, // write data
   input wire logic [3:0] avs_byteenable_i, // byte lanes
   output logic [31:0] avs_readdata_o, // read data
   output logic avs_waitrequest_o, // stall
   input wire logic reference_sample_strobe_i, // reset-level strobe pin
   input wire logic data_sample_strobe_i, // pixel-level strobe pin
   input wire logic converter_output_clock_i, // output clock pin
   input wire logic clamp_request_i, // clamp request pin
   input wire logic [15:0] conv_data_i, // converter result
   input wire logic conv_valid_i, // result valid pulse
   output logic [2:0] cds_ref_capture_o, // reset-level capture pulse, b/g/r
   output logic [2:0] cds_data_capture_o, // pixel capture pulse, b/g/r
   output logic [1:0] mux_sel_o, // connected channel
   output logic [5:0] gain_code_o, // gain code of connected channel
   output logic [6:0] gain_den_o, // gain divisor 80 - code
   output logic [29:0] offset_codes_o, // offset codes b,g,r
   output logic clamp_en_o, // input clamp on
   output logic [15:0] out_data_o, // output data lines
   output logic [1:0] out_tag_o // channel of word on lines
);
   // =====================================================
   // strobe synchronisers
   ccdmx_edge_if ref_e ();
   ccdmx_edge_if dat_e ();
   ccdmx_edge_if ock_e ();
   ccdmx_edge_if clp_e ();
   ccdmx_edge_det u_ref (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .pin_i(reference_sample_strobe_i), .edge_o(ref_e));
   ccdmx_edge_det u_dat (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .pin_i(data_sample_strobe_i), .edge_o(dat_e));
   ccdmx_edge_det u_ock (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .pin_i(converter_output_clock_i), .edge_o(ock_e));
   ccdmx_edge_det u_clp (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .pin_i(clamp_request_i), .edge_o(clp_e));

   // =====================================================
   // register file
   logic [7:0] cfg_q;
   logic [9:0] ofs_q [3];
   logic [5:0] gain_q [3];
   logic wait_q;
   wire req = avs_read_i | avs_write_i;
   wire rd_load = avs_read_i & wait_q;
   wire wr_take = avs_write_i & ~wait_q;
   wire [15:0] wd16 = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : 8'h00,
                       avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00};
   wire [15:0] keep16 = {avs_byteenable_i[1] ? 8'h00 : 8'hff,
                         avs_byteenable_i[0] ? 8'h00 : 8'hff};
   wire hit_cfg = avs_address_i == ccdmx_pkg::REG_CFG;
   wire [2:0] hit_ofs = {avs_address_i == ccdmx_pkg::REG_OFS_B,
                         avs_address_i == ccdmx_pkg::REG_OFS_G,
                         avs_address_i == ccdmx_pkg::REG_OFS_R};
   wire [2:0] hit_gain = {avs_address_i == ccdmx_pkg::REG_GAIN_B,
                          avs_address_i == ccdmx_pkg::REG_GAIN_G,
                          avs_address_i == ccdmx_pkg::REG_GAIN_R};
   wire hit_stat = avs_address_i == ccdmx_pkg::REG_STAT;

   // waitrequest drops for one cycle, one cycle after a request appears
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(req & wait_q);
      end
   end
   assign avs_waitrequest_o = wait_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q <= ccdmx_pkg::CFG_RST;
      end else if (wr_take & hit_cfg) begin
         cfg_q <= (cfg_q & keep16[7:0]) | wd16[7:0];
      end
   end

   for (genvar c = 0; c < 3; c++) begin : g_chreg
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
         if (rst_i) begin
            ofs_q[c] <= ccdmx_pkg::OFS_RST;
            gain_q[c] <= ccdmx_pkg::GAIN_RST;
         end else begin
            if (wr_take & hit_ofs[c]) begin
               ofs_q[c] <= (ofs_q[c] & keep16[9:0]) | wd16[9:0];
            end
            if (wr_take & hit_gain[c]) begin
               gain_q[c] <= (gain_q[c] & keep16[5:0]) | wd16[5:0];
            end
         end
      end
   end

   // =====================================================
   // configuration decode
   // the narrow variant has no normal mode, so demux is forced on
   wire single_mode = cfg_q[ccdmx_pkg::CFG_CH1];
   wire rev_order = cfg_q[ccdmx_pkg::CFG_ORDER];
   wire demux_mode = cfg_q[ccdmx_pkg::CFG_DEMUX] | NARROW_VARIANT;
   wire [1:0] fix_sel = {cfg_q[ccdmx_pkg::CFG_SEL_HI], cfg_q[ccdmx_pkg::CFG_SEL_LO]};

   // =====================================================
   // channel mux
   ccdmx_pkg::ccdmx_chan_type chan_q;
   ccdmx_pkg::ccdmx_chan_type chan_d;
   ccdmx_pkg::ccdmx_chan_type step_ch;
   ccdmx_pkg::ccdmx_chan_type fixed_ch;
   ccdmx_pkg::ccdmx_chan_type first_ch;
   ccdmx_pkg::ccdmx_chan_type tag_q;
   ccdmx_pkg::ccdmx_chan_type res_tag_q;

   assign first_ch = rev_order ? ccdmx_pkg::CH_BLUE : ccdmx_pkg::CH_RED;

   always_comb begin
      case (fix_sel)
         2'h2: fixed_ch = ccdmx_pkg::CH_GREEN;
         2'h1: fixed_ch = ccdmx_pkg::CH_BLUE;
         default: fixed_ch = ccdmx_pkg::CH_RED;
      endcase
   end

   always_comb begin
      case (chan_q)
         ccdmx_pkg::CH_RED: step_ch = rev_order ? ccdmx_pkg::CH_BLUE : ccdmx_pkg::CH_GREEN;
         ccdmx_pkg::CH_GREEN: step_ch = rev_order ? ccdmx_pkg::CH_RED : ccdmx_pkg::CH_BLUE;
         ccdmx_pkg::CH_BLUE: step_ch = rev_order ? ccdmx_pkg::CH_GREEN : ccdmx_pkg::CH_RED;
         default: step_ch = first_ch;
      endcase
   end

   // a ref fall landing with a data fall wins: the line restarts
   always_comb begin
      if (single_mode) begin
         chan_d = fixed_ch;
      end else if (ref_e.fall) begin
         chan_d = first_ch;
      end else if (dat_e.fall) begin
         chan_d = step_ch;
      end else begin
         chan_d = chan_q;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         chan_q <= ccdmx_pkg::CH_RED;
         tag_q <= ccdmx_pkg::CH_RED;
      end else begin
         chan_q <= chan_d;
         if (dat_e.fall) begin
            tag_q <= chan_q;
         end
      end
   end
   assign mux_sel_o = chan_q;

   // =====================================================
   // sampler strobes, clamp and analog codes
   // all three samplers capture together whatever the mode
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cds_ref_capture_o <= 3'h0;
         cds_data_capture_o <= 3'h0;
         clamp_en_o <= 1'b0;
         gain_code_o <= ccdmx_pkg::GAIN_RST;
         gain_den_o <= ccdmx_pkg::GAIN_NUM;
         offset_codes_o <= {3{ccdmx_pkg::OFS_RST}};
      end else begin
         cds_ref_capture_o <= {3{ref_e.fall}};
         cds_data_capture_o <= {3{dat_e.fall}};
         clamp_en_o <= clp_e.level & ref_e.level;
         gain_code_o <= gain_q[chan_q];
         gain_den_o <= ccdmx_pkg::GAIN_NUM - {1'b0, gain_q[chan_q]};
         offset_codes_o <= {ofs_q[2], ofs_q[1], ofs_q[0]};
      end
   end

   // =====================================================
   // converter result and output formatter
   logic [15:0] res_q;
   localparam int BYTE_LSB = NARROW_VARIANT ? ccdmx_pkg::LANE_MID_LSB : ccdmx_pkg::LANE_TOP_LSB;
   wire [15:0] hi_lanes = 16'(res_q[15:8]) << BYTE_LSB;
   wire [15:0] lo_lanes = 16'(res_q[7:0]) << BYTE_LSB;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         res_q <= 16'h0000;
         res_tag_q <= ccdmx_pkg::CH_RED;
      end else if (conv_valid_i) begin
         res_q <= conv_data_i;
         res_tag_q <= tag_q;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_data_o <= 16'h0000;
         out_tag_o <= 2'h0;
      end else if (ock_e.rise) begin
         out_data_o <= demux_mode ? hi_lanes : res_q;
         out_tag_o <= res_tag_q;
      end else if (ock_e.fall & demux_mode) begin
         out_data_o <= lo_lanes;
      end
   end

   // =====================================================
   // status and read data
   wire [31:0] stat_word = {24'h000000, clp_e.level, ock_e.level, dat_e.level,
                            ref_e.level, 2'(tag_q), 2'(chan_q)};
   wire [31:0] rd_word = hit_cfg ? 32'(cfg_q) :
                         hit_ofs[0] ? 32'(ofs_q[0]) :
                         hit_ofs[1] ? 32'(ofs_q[1]) :
                         hit_ofs[2] ? 32'(ofs_q[2]) :
                         hit_gain[0] ? 32'(gain_q[0]) :
                         hit_gain[1] ? 32'(gain_q[1]) :
                         hit_gain[2] ? 32'(gain_q[2]) :
                         hit_stat ? stat_word : ccdmx_pkg::RD_NONE;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_readdata_o <= ccdmx_pkg::RD_NONE;
      end else if (rd_load) begin
         // loaded while still stalling, so the word stands at the edge that takes it
         avs_readdata_o <= rd_word;
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence pulse3_s;
      cds_ref_capture_o == 3'h7 ##1 cds_ref_capture_o == 3'h0;
   endsequence
   sequence dpulse3_s;
      cds_data_capture_o == 3'h7 ##1 cds_data_capture_o == 3'h0;
   endsequence

   ref_capture_a: assert property (ref_e.fall |=> pulse3_s)
      else $error("reference capture pulse wrong");
   data_capture_a: assert property (dat_e.fall |=> dpulse3_s)
      else $error("data capture pulse wrong");
   mux_step_a: assert property (!single_mode && dat_e.fall && !ref_e.fall && !rev_order
      && chan_q == ccdmx_pkg::CH_RED |=> chan_q == ccdmx_pkg::CH_GREEN)
      else $error("mux did not advance red to green");
   mux_rev_a: assert property (!single_mode && dat_e.fall && !ref_e.fall && rev_order
      && chan_q == ccdmx_pkg::CH_BLUE |=> chan_q == ccdmx_pkg::CH_GREEN)
      else $error("reverse order wrong");
   mux_restart_a: assert property (!single_mode && ref_e.fall |=>
      chan_q == (rev_order ? ccdmx_pkg::CH_BLUE : ccdmx_pkg::CH_RED))
      else $error("mux did not restart");
   single_hold_a: assert property (single_mode && $stable(cfg_q) && fix_sel == 2'h1
      |=> chan_q == ccdmx_pkg::CH_BLUE)
      else $error("single channel not held");
   clamp_gate_a: assert property (clamp_en_o == $past(clp_e.level & ref_e.level))
      else $error("clamp gating wrong");
   gain_den_a: assert property (gain_den_o == ccdmx_pkg::GAIN_NUM - {1'b0, gain_code_o})
      else $error("gain divisor wrong");
   normal_out_a: assert property (ock_e.rise && !demux_mode |=> out_data_o == $past(res_q))
      else $error("normal output wrong");
   demux_lo_a: assert property (ock_e.fall && demux_mode && !ock_e.rise
      |=> out_data_o == (16'($past(res_q[7:0])) << BYTE_LSB))
      else $error("low byte not on lanes");
   unused_low_a: assert property (demux_mode && $stable(demux_mode) && ock_e.rise
      |=> (out_data_o & ~(16'h00ff << BYTE_LSB)) == 16'h0000)
      else $error("unused lines not low");
endmodule : ccdmx_seq

//--- ccdmx_pkg.sv
// constants, field positions and channel type for the ccd channel sequencer
// assumes a single 20 MHz system clock domain and 32-bit avalon-mm access
// Function
// - three samplers capture together, one converter
// - reset level on ref fall, pixel on data
// - mux advances on each data strobe fall
// - order bit: red-first or blue-first sequence
// - ref strobe fall returns mux to first
// - format bit: normal or byte demux
// - normal mode drives all sixteen lines
// - demux: high byte rise, low byte fall
// - narrow variant uses middle eight lines
// - per-channel 6-bit gain code applied
// - gain equals 80 over 80 minus code
// - per-channel 10-bit offset code
// - clamp only when request and ref high
// - count bit: single or three channel
// - single mode holds selected channel
package ccdmx_pkg;
   // =====================================================
   // register map, byte addresses
   localparam logic [4:0] REG_CFG = 5'h00;
   localparam logic [4:0] REG_OFS_R = 5'h04;
   localparam logic [4:0] REG_OFS_G = 5'h08;
   localparam logic [4:0] REG_OFS_B = 5'h0c;
   localparam logic [4:0] REG_GAIN_R = 5'h10;
   localparam logic [4:0] REG_GAIN_G = 5'h14;
   localparam logic [4:0] REG_GAIN_B = 5'h18;
   localparam logic [4:0] REG_STAT = 5'h1c;
   // =====================================================
   // configuration fields
   localparam int CFG_CH1 = 3;
   localparam int CFG_SEL_LO = 4;
   localparam int CFG_SEL_HI = 5;
   localparam int CFG_ORDER = 6;
   localparam int CFG_DEMUX = 7;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [9:0] OFS_RST = 10'h000;
   localparam logic [5:0] GAIN_RST = 6'h00;
   // =====================================================
   // widths and lanes
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int LANE_TOP_LSB = 8;
   localparam int LANE_MID_LSB = 6;
   localparam logic [6:0] GAIN_NUM = 7'h50;
   localparam logic [31:0] RD_NONE = 32'h0000_0000;
   // =====================================================
   typedef enum logic [1:0] {CH_RED, CH_GREEN, CH_BLUE} ccdmx_chan_type;
endpackage : ccdmx_pkg

//--- ccdmx_edge_if.sv
// synchronised level and edge pulses of one outside strobe
// assumes producer and consumer share sys_clk_i
`timescale 1ns/1ps
interface ccdmx_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : ccdmx_edge_if

//--- ccdmx_edge_det.sv
// two-flop synchroniser plus edge finder for one outside pin
// assumes the pin is slower than half of sys_clk_i
`timescale 1ns/1ps
module ccdmx_edge_det (
   input wire logic sys_clk_i, // system clock
   input wire logic rst_i, // async reset, high
   input wire logic pin_i, // outside pin
   ccdmx_edge_if.src edge_o // level and edges
);
   logic meta_q;
   logic sync_q;
   logic last_q;
   // the first stage feeds only the second
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end
   assign edge_o.level = sync_q;
   assign edge_o.rise = sync_q & ~last_q;
   assign edge_o.fall = ~sync_q & last_q;
endmodule : ccdmx_edge_det

//--- ccdmx_tgen_model.sv
// stand-in for the outside timing generator and signal processor on the strobe pins
// assumes one bench process calls its tasks, all on sys_clk_i rising edges
`timescale 1ns/1ps
module ccdmx_tgen_model (
   input wire logic sys_clk_i, // system clock
   output logic ref_o, // reference-sample strobe
   output logic data_o, // data-sample strobe
   output logic ock_o, // converter output clock
   output logic clamp_o // clamp request
);
   // =====================================================
   // pins stand still between pixels, so no clock runs outside a frame
   initial begin
      {clamp_o, ock_o, data_o, ref_o} = 4'h0;
   end
   task automatic put(input logic [2:0] v, input int n);
      @(posedge sys_clk_i);
      {ock_o, data_o, ref_o} <= v;
      repeat (n) @(posedge sys_clk_i);
   endtask : put
   // held high for pixel clamping, or only over dummy pixels for line clamping
   task automatic clamp(input logic v);
      @(posedge sys_clk_i);
      clamp_o <= v;
   endtask : clamp
   // one output clock period; the strobe falls two cycles into the low phase
   task automatic pixel(input logic is_ref);
      put({1'b1, ~is_ref, is_ref}, 3);
      put({1'b0, ~is_ref, is_ref}, 1);
      put(3'h0, 1);
   endtask : pixel
endmodule : ccdmx_tgen_model

//--- test_ccdmx_seq.sv
// self-checking bench for the channel sequencer, wide and narrow variants side by side
// assumes the timing model above drives every strobe pin
`timescale 1ns/1ps
module test_ccdmx_seq;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] avs_address_i = 5'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'h3;
   logic [15:0] conv_data_i = 16'h0;
   logic conv_valid_i = 1'b0;
   logic [31:0] avs_readdata_o, q;
   logic avs_waitrequest_o, ref_s, dat_s, ock_s, clp_s, clamp_en_o;
   logic [2:0] cds_ref_capture_o, cds_data_capture_o;
   logic [1:0] mux_sel_o, out_tag_o;
   logic [5:0] gain_code_o;
   logic [6:0] gain_den_o;
   logic [29:0] offset_codes_o;
   logic [15:0] out_data_o, out_data_n;
   logic [5:0] g[3] = '{6'h00, 6'h15, 6'h3f};
   logic [7:0] sc[3] = '{8'h08, 8'h28, 8'h18};
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_dcap = 0;
   int n_data = 0;
   int n_rcap = 0;
   int n_ref = 0;
   int c;

   always #25 sys_clk_i = ~sys_clk_i;

   ccdmx_tgen_model u_ccdmx_tgen_model (.sys_clk_i(sys_clk_i), .ref_o(ref_s), .data_o(dat_s), .ock_o(ock_s),
      .clamp_o(clp_s));
   ccdmx_seq u_ccdmx_seq (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .reference_sample_strobe_i(ref_s), .data_sample_strobe_i(dat_s), .converter_output_clock_i(ock_s),
      .clamp_request_i(clp_s), .conv_data_i(conv_data_i), .conv_valid_i(conv_valid_i),
      .cds_ref_capture_o(cds_ref_capture_o), .cds_data_capture_o(cds_data_capture_o), .mux_sel_o(mux_sel_o),
      .gain_code_o(gain_code_o), .gain_den_o(gain_den_o), .offset_codes_o(offset_codes_o),
      .clamp_en_o(clamp_en_o), .out_data_o(out_data_o), .out_tag_o(out_tag_o));
   ccdmx_seq #(.NARROW_VARIANT(1'b1)) u_ccdmx_seq_n (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(),
      .avs_waitrequest_o(), .reference_sample_strobe_i(ref_s), .data_sample_strobe_i(dat_s),
      .converter_output_clock_i(ock_s), .clamp_request_i(clp_s), .conv_data_i(conv_data_i),
      .conv_valid_i(conv_valid_i), .cds_ref_capture_o(), .cds_data_capture_o(), .mux_sel_o(), .gain_code_o(),
      .gain_den_o(), .offset_codes_o(), .clamp_en_o(), .out_data_o(out_data_n), .out_tag_o());

   // a capture held longer than one cycle would be counted twice
   always @(posedge sys_clk_i) begin
      if (cds_data_capture_o === 3'h7) n_dcap++;
      if (cds_ref_capture_o === 3'h7) n_rcap++;
   end

   // =====================================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      samples_checked++;
      if (v !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus
   task automatic px(input logic r);
      u_ccdmx_tgen_model.pixel(r);
      if (r) n_ref++;
      else n_data++;
      repeat (5) @(posedge sys_clk_i);
   endtask : px
   task automatic word(input logic [15:0] w);
      @(posedge sys_clk_i);
      conv_data_i <= w;
      conv_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      conv_valid_i <= 1'b0;
      u_ccdmx_tgen_model.put(3'h4, 5);
   endtask : word
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_mismatch++;
      test_done;
   end

   // =====================================================
   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      for (int a = 0; a < 8; a++) begin
         bus(1'b0, 5'(a * 4), 32'h0);
         chk("reset value", 32'h0, q);
      end
      bus(1'b0, 5'h02, 32'h0);
      chk("unmapped read", 32'h0, q);
      bus(1'b1, ccdmx_pkg::REG_OFS_R, 32'hffff_ffff);
      bus(1'b1, ccdmx_pkg::REG_OFS_G, 32'h0000_0200);
      bus(1'b1, ccdmx_pkg::REG_OFS_B, 32'h0000_0001);
      bus(1'b0, ccdmx_pkg::REG_OFS_R, 32'h0);
      chk("offset red", 32'h3ff, q);
      chk("offset codes", {2'h0, 10'h001, 10'h200, 10'h3ff}, offset_codes_o);
      bus(1'b1, ccdmx_pkg::REG_GAIN_G, 32'h15);
      bus(1'b1, ccdmx_pkg::REG_GAIN_B, 32'hffff_ffff);
      bus(1'b0, ccdmx_pkg::REG_GAIN_B, 32'h0);
      chk("gain blue", 32'h3f, q);
      for (int o = 0; o < 2; o++) begin
         bus(1'b1, ccdmx_pkg::REG_CFG, o ? 32'h40 : 32'h0);
         for (int k = 0; k < 3; k++) begin
            px(k == 0);
            c = o ? 2 - k : k;
            chk("mux_sel", c, mux_sel_o);
            chk("gain_code", g[c], gain_code_o);
            chk("gain_den", 7'h50 - g[c], gain_den_o);
         end
      end
      for (int s = 0; s < 3; s++) begin
         bus(1'b1, ccdmx_pkg::REG_CFG, sc[s]);
         px(1'b1);
         px(1'b0);
         chk("single mux_sel", s, mux_sel_o);
      end
      bus(1'b1, ccdmx_pkg::REG_CFG, 32'h0);
      px(1'b1);
      px(1'b0);
      word(16'ha5c3);
      chk("normal out", 16'ha5c3, out_data_o);
      chk("tag", ccdmx_pkg::CH_RED, out_tag_o);
      u_ccdmx_tgen_model.put(3'h0, 5);
      bus(1'b1, ccdmx_pkg::REG_CFG, 32'h80);
      px(1'b1);
      px(1'b0);
      px(1'b0);
      word(16'h5a3c);
      chk("demux high", 16'h5a00, out_data_o);
      chk("narrow high", {2'h0, 8'h5a, 6'h00}, out_data_n);
      chk("tag", ccdmx_pkg::CH_GREEN, out_tag_o);
      u_ccdmx_tgen_model.put(3'h0, 5);
      chk("demux low", 16'h3c00, out_data_o);
      chk("narrow low", {2'h0, 8'h3c, 6'h00}, out_data_n);
      chk("ref captures", n_ref, n_rcap);
      u_ccdmx_tgen_model.clamp(1'b1);
      u_ccdmx_tgen_model.put(3'h5, 6);
      chk("clamp on", 1'b1, clamp_en_o);
      u_ccdmx_tgen_model.put(3'h0, 6);
      chk("clamp ref low", 1'b0, clamp_en_o);
      u_ccdmx_tgen_model.clamp(1'b0);
      u_ccdmx_tgen_model.put(3'h5, 6);
      chk("clamp no request", 1'b0, clamp_en_o);
      u_ccdmx_tgen_model.put(3'h0, 6);
      chk("data captures", n_data, n_dcap);
      test_done;
   end
endmodule : test_ccdmx_seq
